/* rtl/link_cycle_pkg.sv */
package link_cycle_pkg;
    localparam logic [7:0]  ADDR_FAIRNESS     = 8'hdc;
    localparam logic [7:0]  ADDR_LINK_SET     = 8'he0;
    localparam logic [7:0]  ADDR_LINK_CLEAR   = 8'he4;
    localparam logic [7:0]  ADDR_CYCLE_STATUS = 8'hf0;
    localparam logic [7:0]  ADDR_CYCLE_EVENT  = 8'hf4;
    localparam int          BUDGET_W          = 8;
    localparam logic [7:0]  BUDGET_RESET      = 8'h00;
    localparam int          POS_ROLL_SRC      = 22;
    localparam int          POS_CYC_MASTER    = 21;
    localparam int          POS_TIMER_EN      = 20;
    localparam int          POS_PHY_ACCEPT    = 10;
    localparam int          POS_SELFID_ACCEPT = 9;
    localparam int          POS_SYNC_LOCK     = 6;
    localparam int          POS_OVERRUN       = 0;
    localparam logic [31:0] LINK_CTRL_MASK    = 32'h0070_0640;
    localparam logic [31:0] LINK_CLEARABLE    = 32'h0070_0600;
    localparam int          CYCLE_CLK_HZ      = 24576000;
    localparam int          CYCLE_TIME_NS     = 125000;
    localparam int          CYCLE_TICKS       = 3072;
    localparam int          OFFSET_W          = 12;
    localparam logic [1:0]  RESP_OKAY         = 2'b00;
    localparam logic [1:0]  RESP_SLVERR       = 2'b10;
endpackage

/* rtl/edge_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module edge_sync
    import link_cycle_pkg::*;
(
    input  wire logic clk,
    input  wire logic reset,
    input  wire logic clkEn,
    input  wire logic asyncIn,
    output logic      risePulse
);
    logic meta_q;
    logic sync_q;
    logic prev_q;

    // first stage feeds only the second
    always_ff @(posedge clk) begin
        if (reset) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            prev_q <= 1'b0;
        end else if (clkEn) begin
            meta_q <= asyncIn;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    assign risePulse = clkEn & sync_q & ~prev_q;
endmodule
`default_nettype wire

/* rtl/cycle_offset_counter.sv */
`timescale 1ns/1ps
`default_nettype none
module cycle_offset_counter
    import link_cycle_pkg::*;
#(
    parameter int TICKS = CYCLE_TICKS,
    parameter int W     = OFFSET_W
) (
    input  wire logic         clk,
    input  wire logic         reset,
    input  wire logic         clkEn,
    input  wire logic         countEn,
    input  wire logic         extSource,
    input  wire logic         extEdge,
    input  wire logic         syncLoad,
    output logic [W-1:0]      offset,
    output logic              rollover
);
    localparam logic [W-1:0] LAST = W'(TICKS - 1);
    logic [W-1:0] count_q;
    logic         roll;

    always_comb begin
        roll = 1'b0;
        if (countEn) begin
            if (extSource) begin
                roll = extEdge;
            end else begin
                roll = (count_q == LAST);
            end
        end
    end

    // external source still counts but wraps only on its edge
    always_ff @(posedge clk) begin
        if (reset) begin
            count_q <= '0;
        end else if (clkEn) begin
            if (syncLoad || roll) begin
                count_q <= '0;
            end else if (countEn && count_q != LAST) begin
                count_q <= count_q + W'(1);
            end
        end
    end

    assign offset   = count_q;
    assign rollover = clkEn & roll;
endmodule
`default_nettype wire

/* rtl/link_cycle_control_regs.sv */
// The implementer's own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module link_cycle_control_regs
    import link_cycle_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic        clkEn,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        ext_cycle_input,
    input  wire logic        overrunEvent,
    input  wire logic        rxCycleStart,
    input  wire logic        rxPhyPacket,
    input  wire logic        rxSelfidPacket,
    input  wire logic        asyncReceiveEnabled,
    input  wire logic        isoSyncFilterSw,
    output logic             iso_sync_filter_bit,
    output logic             phyPacketAccept,
    output logic             selfidPacketAccept,
    output logic             cycleStartSend,
    output logic [11:0]      cycleOffset,
    output logic [7:0]       fairnessBudget
);
    logic [BUDGET_W-1:0] budget_q;
    logic        rollover_source_select;
    logic        cycle_start_generator_en;
    logic        cycle_offset_count_en;
    logic        accept_phy_packets;
    logic        accept_selfid_packets;
    logic        sync_filter_force_lock;
    logic        cycle_overrun_flag;
    logic [7:0]  awAddr_q;
    logic        awHave_q;
    logic [31:0] wData_q;
    logic [3:0]  wStrb_q;
    logic        wHave_q;
    logic        bValid_q;
    logic [1:0]  bResp_q;
    logic        rValid_q;
    logic [31:0] rData_q;
    logic [1:0]  rResp_q;
    logic        doWrite;
    logic [31:0] wMask;
    logic        setHit;
    logic        clrHit;
    logic        extEdge;
    logic        roll;
    logic        cycleStartSend_q;
    logic        phyAccept_q;
    logic        selfidAccept_q;

    function automatic logic [31:0] strb_mask(input logic [3:0] s);
        logic [31:0] m;
        m = '0;
        for (int i = 0; i < 4; i++) begin
            m[i*8 +: 8] = {8{s[i]}};
        end
        return m;
    endfunction

    function automatic logic [31:0] link_view(
        input logic src, input logic mst, input logic ten,
        input logic phy, input logic sid, input logic lck);
        logic [31:0] v;
        v = '0;
        v[POS_ROLL_SRC]      = src;
        v[POS_CYC_MASTER]    = mst;
        v[POS_TIMER_EN]      = ten;
        v[POS_PHY_ACCEPT]    = phy;
        v[POS_SELFID_ACCEPT] = sid;
        v[POS_SYNC_LOCK]     = lck;
        return v & LINK_CTRL_MASK;
    endfunction

    // each write channel is taken once and held until the write fires
    assign s_axi_awready = ~awHave_q & ~bValid_q;
    assign s_axi_wready  = ~wHave_q & ~bValid_q;
    assign s_axi_arready = ~rValid_q;
    assign doWrite       = clkEn & awHave_q & wHave_q & ~bValid_q;
    assign wMask         = strb_mask(wStrb_q) & wData_q;
    assign setHit        = doWrite & (awAddr_q[7:2] == ADDR_LINK_SET[7:2]);
    assign clrHit        = doWrite & (awAddr_q[7:2] == ADDR_LINK_CLEAR[7:2]);

    always_ff @(posedge clk) begin
        if (reset) begin
            awHave_q <= 1'b0;
            awAddr_q <= '0;
            wHave_q  <= 1'b0;
            wData_q  <= '0;
            wStrb_q  <= '0;
        end else if (clkEn) begin
            if (s_axi_awvalid && s_axi_awready) begin
                awHave_q <= 1'b1;
                awAddr_q <= s_axi_awaddr;
            end else if (doWrite) begin
                awHave_q <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wHave_q <= 1'b1;
                wData_q <= s_axi_wdata;
                wStrb_q <= s_axi_wstrb;
            end else if (doWrite) begin
                wHave_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            bValid_q <= 1'b0;
            bResp_q  <= RESP_OKAY;
        end else if (clkEn) begin
            if (doWrite) begin
                bValid_q <= 1'b1;
                unique case (awAddr_q[7:2])
                    ADDR_FAIRNESS[7:2], ADDR_LINK_SET[7:2],
                    ADDR_LINK_CLEAR[7:2], ADDR_CYCLE_EVENT[7:2]: begin
                        bResp_q <= RESP_OKAY;
                    end
                    default: begin
                        bResp_q <= RESP_SLVERR;
                    end
                endcase
            end else if (s_axi_bready) begin
                bValid_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            budget_q <= BUDGET_RESET;
        end else if (doWrite && awAddr_q[7:2] == ADDR_FAIRNESS[7:2]
                     && wStrb_q[0]) begin
            budget_q <= wData_q[BUDGET_W-1:0];
        end
    end

    // plain set/clear flags
    always_ff @(posedge clk) begin
        if (reset) begin
            rollover_source_select <= 1'b0;
            cycle_offset_count_en  <= 1'b0;
            accept_phy_packets     <= 1'b0;
            accept_selfid_packets  <= 1'b0;
        end else if (setHit) begin
            rollover_source_select <= rollover_source_select
                                      | wMask[POS_ROLL_SRC];
            cycle_offset_count_en  <= cycle_offset_count_en
                                      | wMask[POS_TIMER_EN];
            accept_phy_packets     <= accept_phy_packets
                                      | wMask[POS_PHY_ACCEPT];
            accept_selfid_packets  <= accept_selfid_packets
                                      | wMask[POS_SELFID_ACCEPT];
        end else if (clrHit) begin
            rollover_source_select <= rollover_source_select
                                      & ~wMask[POS_ROLL_SRC];
            cycle_offset_count_en  <= cycle_offset_count_en
                                      & ~wMask[POS_TIMER_EN];
            accept_phy_packets     <= accept_phy_packets
                                      & ~wMask[POS_PHY_ACCEPT];
            accept_selfid_packets  <= accept_selfid_packets
                                      & ~wMask[POS_SELFID_ACCEPT];
        end
    end

    // overrun is sticky; a new event beats a software clear
    always_ff @(posedge clk) begin
        if (reset) begin
            cycle_overrun_flag <= 1'b0;
        end else if (clkEn) begin
            if (overrunEvent) begin
                cycle_overrun_flag <= 1'b1;
            end else if (doWrite && awAddr_q[7:2] == ADDR_CYCLE_EVENT[7:2]
                         && wMask[POS_OVERRUN]) begin
                cycle_overrun_flag <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            cycle_start_generator_en <= 1'b0;
        end else if (clkEn) begin
            if (overrunEvent) begin
                cycle_start_generator_en <= 1'b0;
            end else if (setHit && wMask[POS_CYC_MASTER]
                         && !cycle_overrun_flag) begin
                cycle_start_generator_en <= 1'b1;
            end else if (clrHit && wMask[POS_CYC_MASTER]) begin
                cycle_start_generator_en <= 1'b0;
            end
        end
    end

    // lock can only be set; only reset drops it
    always_ff @(posedge clk) begin
        if (reset) begin
            sync_filter_force_lock <= 1'b0;
        end else if (setHit && wMask[POS_SYNC_LOCK]) begin
            sync_filter_force_lock <= 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            rValid_q <= 1'b0;
            rData_q  <= '0;
            rResp_q  <= RESP_OKAY;
        end else if (clkEn) begin
            if (s_axi_arvalid && s_axi_arready) begin
                rValid_q <= 1'b1;
                rResp_q  <= RESP_OKAY;
                unique case (s_axi_araddr[7:2])
                    ADDR_FAIRNESS[7:2]: begin
                        rData_q <= 32'(budget_q);
                    end
                    ADDR_LINK_SET[7:2], ADDR_LINK_CLEAR[7:2]: begin
                        rData_q <= link_view(rollover_source_select,
                            cycle_start_generator_en, cycle_offset_count_en,
                            accept_phy_packets, accept_selfid_packets,
                            sync_filter_force_lock);
                    end
                    ADDR_CYCLE_STATUS[7:2]: begin
                        rData_q <= 32'(cycleOffset);
                    end
                    ADDR_CYCLE_EVENT[7:2]: begin
                        rData_q <= 32'(cycle_overrun_flag);
                    end
                    default: begin
                        rData_q <= '0;
                        rResp_q <= RESP_SLVERR;
                    end
                endcase
            end else if (s_axi_rready) begin
                rValid_q <= 1'b0;
            end
        end
    end

    edge_sync u_edge (
        .clk       (clk),
        .reset     (reset),
        .clkEn     (clkEn),
        .asyncIn   (ext_cycle_input),
        .risePulse (extEdge)
    );

    cycle_offset_counter u_count (
        .clk       (clk),
        .reset     (reset),
        .clkEn     (clkEn),
        .countEn   (cycle_offset_count_en),
        .extSource (rollover_source_select),
        .extEdge   (extEdge),
        .syncLoad  (~cycle_start_generator_en & rxCycleStart),
        .offset    (cycleOffset),
        .rollover  (roll)
    );

    always_ff @(posedge clk) begin
        if (reset) begin
            cycleStartSend_q <= 1'b0;
            phyAccept_q      <= 1'b0;
            selfidAccept_q   <= 1'b0;
        end else if (clkEn) begin
            cycleStartSend_q <= roll & cycle_start_generator_en;
            phyAccept_q      <= rxPhyPacket & accept_phy_packets
                                & asyncReceiveEnabled;
            selfidAccept_q   <= rxSelfidPacket
                                & accept_selfid_packets;
        end
    end

    assign iso_sync_filter_bit = sync_filter_force_lock
                                 | isoSyncFilterSw;
    assign cycleStartSend     = cycleStartSend_q;
    assign phyPacketAccept    = phyAccept_q;
    assign selfidPacketAccept = selfidAccept_q;
    assign fairnessBudget     = budget_q;
    assign s_axi_bvalid       = bValid_q;
    assign s_axi_bresp        = bResp_q;
    assign s_axi_rvalid       = rValid_q;
    assign s_axi_rdata        = rData_q;
    assign s_axi_rresp        = rResp_q;
endmodule
`default_nettype wire

/* sim/phy_cycle_source.sv */
`timescale 1ns/1ps
`default_nettype none
module phy_cycle_source #(
    parameter int PERIOD = 1000
) (
    input  wire logic clk,
    input  wire logic reset,
    output logic      ext_cycle_input
);
    int cnt_q;
    // free running: the far side keeps sending cycle marks regardless
    always_ff @(posedge clk) begin
        if (reset || cnt_q == PERIOD - 1) begin
            cnt_q <= 0;
        end else begin
            cnt_q <= cnt_q + 1;
        end
    end
    // short high pulse, rising edge is the event
    assign ext_cycle_input = cnt_q < 8;
endmodule
`default_nettype wire

/* sim/link_cycle_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module link_cycle_properties
    import link_cycle_pkg::*;
(
    input wire logic        clk,
    input wire logic        reset,
    input wire logic        clkEn,
    input wire logic [7:0]  s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        rxPhyPacket,
    input wire logic        rxSelfidPacket,
    input wire logic        asyncReceiveEnabled,
    input wire logic        isoSyncFilterSw,
    input wire logic        iso_sync_filter_bit,
    input wire logic        phyPacketAccept,
    input wire logic        selfidPacketAccept,
    input wire logic        cycleStartSend,
    input wire logic [11:0] cycleOffset
);
    logic [7:0] rdAddr_q;
    logic       lockSeen_q;
    logic       rdLink;
    assign rdLink = rdAddr_q == ADDR_LINK_SET || rdAddr_q == ADDR_LINK_CLEAR;
    always_ff @(posedge clk) begin
        if (s_axi_arvalid && s_axi_arready && clkEn) begin
            rdAddr_q <= s_axi_araddr;
        end
    end
    // once lock is seen set the filter bit must stay high until reset
    always_ff @(posedge clk) begin
        if (reset) begin
            lockSeen_q <= 1'b0;
        end else if (s_axi_rvalid && rdLink
                     && s_axi_rdata[POS_SYNC_LOCK]) begin
            lockSeen_q <= 1'b1;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    a_fair_upper_zero: assert property (s_axi_rvalid &&
        rdAddr_q == ADDR_FAIRNESS |-> s_axi_rdata[31:8] == 24'h0)
        else $error("fairness upper bits not zero");
    a_link_rsvd_zero: assert property (s_axi_rvalid && rdLink
        |-> (s_axi_rdata & ~LINK_CTRL_MASK) == 32'h0)
        else $error("link reserved bits not zero");
    a_lock_forces_bit: assert property (lockSeen_q
        |-> iso_sync_filter_bit) else $error("lock did not force bit");
    a_sw_bit_passes: assert property (isoSyncFilterSw
        |-> iso_sync_filter_bit) else $error("software bit lost");
    a_phy_accept_cause: assert property (phyPacketAccept
        |-> $past(rxPhyPacket && asyncReceiveEnabled))
        else $error("phy accept without cause");
    a_selfid_cause: assert property (selfidPacketAccept
        |-> $past(rxSelfidPacket)) else $error("selfid accept without cause");
    a_offset_steps: assert property ($changed(cycleOffset)
        |-> cycleOffset == $past(cycleOffset) + 12'd1 || cycleOffset == 12'd0)
        else $error("offset jumped");
    a_offset_range: assert property (cycleOffset <= 12'd3071)
        else $error("offset past wrap value");
    a_start_at_wrap: assert property (cycleStartSend
        |-> cycleOffset < 12'd2) else $error("cycle start off wrap");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready
        && clkEn |=> s_axi_rvalid) else $error("read not answered");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata moved");
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp moved");
    c_start: cover property (cycleStartSend);
    c_phy: cover property (phyPacketAccept);
    c_selfid: cover property (selfidPacketAccept);
endmodule
bind link_cycle_control_regs link_cycle_properties u_props (.*);
`default_nettype wire

/* sim/link_cycle_control_regs_test.sv */
`timescale 1ns/1ps
`default_nettype none
module link_cycle_control_regs_test
    import link_cycle_pkg::*;
;
    localparam int PERIOD = 1000;
    logic        clk, reset, clkEn, ext_cycle_input;
    logic [7:0]  s_axi_awaddr, s_axi_araddr, fairnessBudget, bud;
    logic [31:0] s_axi_wdata, s_axi_rdata, got, flags, n;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic        s_axi_rvalid, s_axi_rready, overrunEvent, rxCycleStart;
    logic        rxPhyPacket, rxSelfidPacket, asyncReceiveEnabled;
    logic        isoSyncFilterSw, iso_sync_filter_bit, phyPacketAccept;
    logic        selfidPacketAccept, cycleStartSend;
    logic [11:0] cycleOffset;
    int          miscompares, check_count, cyc;
    link_cycle_control_regs dut (.*);
    phy_cycle_source #(.PERIOD(PERIOD)) phy (.*);
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 40000) begin
            miscompares++;
            report_and_stop();
        end
    end
    // ready and answers are taken at the rising edge, as the slave sees them
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic b;
        @(posedge clk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        b = 1'b0;
        while (!b) begin
            @(posedge clk);
            b = s_axi_bvalid;
            resp = s_axi_bresp;
            if (s_axi_awvalid && s_axi_awready) begin
                s_axi_awvalid <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                s_axi_wvalid <= 1'b0;
            end
        end
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        logic r;
        @(posedge clk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        r = 1'b0;
        while (!r) begin
            @(posedge clk);
            r = s_axi_rvalid;
            got = s_axi_rdata;
            resp = s_axi_rresp;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arvalid <= 1'b0;
            end
        end
        s_axi_rready <= 1'b0;
    endtask
    function automatic logic [31:0] link_next(input logic [31:0] f,
        input logic [31:0] d, input logic clr);
        return clr ? (f & ~(d & LINK_CLEARABLE)) : ((f | d) & LINK_CTRL_MASK);
    endfunction
    task automatic lw(input logic clr, input logic [31:0] d);
        wr(clr ? ADDR_LINK_CLEAR : ADDR_LINK_SET, d);
        flags = link_next(flags, d, clr);
    endtask
    task automatic count_starts(input int len);
        n = 0;
        repeat (len) begin
            @(negedge clk);
            n += cycleStartSend;
        end
    endtask
    initial begin
        {reset, clkEn, s_axi_wstrb} = 6'h3f;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, flags, bud} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid,
         s_axi_rready, overrunEvent, rxCycleStart, rxPhyPacket,
         rxSelfidPacket, asyncReceiveEnabled, isoSyncFilterSw} = '0;
        void'($urandom(32'h1829));
        repeat (12) @(posedge clk);
        reset <= 1'b0;
        rd(ADDR_FAIRNESS);
        check(got, 32'h0);
        check(iso_sync_filter_bit, 1'b0);
        isoSyncFilterSw <= 1'b1;
        @(posedge clk);
        check(iso_sync_filter_bit, 1'b1);
        isoSyncFilterSw <= 1'b0;
        for (int i = 0; i < 12; i++) begin
            n = (i == 0) ? 32'hffff_ffff : $urandom;
            s_axi_wstrb <= (i == 0) ? 4'hf : 4'($urandom);
            wr(ADDR_FAIRNESS, n);
            check(resp, RESP_OKAY);
            // budget byte lands only when its lane is strobed
            if (s_axi_wstrb[0]) begin
                bud = n[7:0];
            end
            s_axi_wstrb <= 4'hf;
            rd(ADDR_FAIRNESS);
            check(got, {24'h0, bud});
            check(fairnessBudget, bud);
            lw(i[0], $urandom);
            rd(i[1] ? ADDR_LINK_CLEAR : ADDR_LINK_SET);
            check(got, flags);
        end
        lw(1'b0, 32'hffff_ffff);
        lw(1'b1, 32'hffff_ffff);
        rd(ADDR_LINK_CLEAR);
        check(got, 32'h0000_0040);
        check(iso_sync_filter_bit, 1'b1);
        rd(8'h40);
        check(got, 32'h0);
        check(resp, RESP_SLVERR);
        wr(8'h40, 32'h0);
        check(resp, RESP_SLVERR);
        @(negedge clk);
        n = cycleOffset;
        repeat (20) @(negedge clk);
        check(cycleOffset, n[11:0]);
        lw(1'b0, 32'h1 << POS_TIMER_EN);
        @(negedge clk);
        n = cycleOffset;
        repeat (10) @(negedge clk);
        check(cycleOffset, (n + 10) % CYCLE_TICKS);
        // clock enable low must freeze the running counter
        @(posedge clk);
        clkEn <= 1'b0;
        @(negedge clk);
        n = cycleOffset;
        repeat (10) @(negedge clk);
        check(cycleOffset, n[11:0]);
        @(posedge clk);
        clkEn <= 1'b1;
        lw(1'b0, 32'h1 << POS_CYC_MASTER);
        count_starts(3 * CYCLE_TICKS);
        check(n, 3);
        lw(1'b0, 32'h1 << POS_ROLL_SRC);
        repeat (PERIOD) @(negedge clk);
        count_starts(3 * PERIOD);
        check(n, 3);
        lw(1'b1, 32'h0060_0000);
        count_starts(PERIOD);
        check(n, 0);
        @(posedge clk);
        rxCycleStart <= 1'b1;
        @(posedge clk);
        rxCycleStart <= 1'b0;
        @(negedge clk);
        check(cycleOffset, 32'h0);
        lw(1'b0, 32'h1 << POS_CYC_MASTER);
        @(posedge clk);
        overrunEvent <= 1'b1;
        @(posedge clk);
        overrunEvent <= 1'b0;
        rd(ADDR_LINK_SET);
        check(got[POS_CYC_MASTER], 1'b0);
        rd(ADDR_CYCLE_EVENT);
        check(got, 32'h1);
        wr(ADDR_LINK_SET, 32'h1 << POS_CYC_MASTER);
        rd(ADDR_LINK_SET);
        check(got[POS_CYC_MASTER], 1'b0);
        wr(ADDR_CYCLE_EVENT, 32'h1);
        wr(ADDR_LINK_SET, 32'h1 << POS_CYC_MASTER);
        rd(ADDR_LINK_SET);
        check(got[POS_CYC_MASTER], 1'b1);
        for (int k = 0; k < 4; k++) begin
            lw(!k[0], 32'h1 << POS_PHY_ACCEPT);
            // selfid accept flag set when k[1] is one, cleared otherwise
            lw(!k[1], 32'h1 << POS_SELFID_ACCEPT);
            @(posedge clk);
            asyncReceiveEnabled <= 1'($urandom);
            rxPhyPacket <= 1'b1;
            rxSelfidPacket <= 1'b1;
            @(posedge clk);
            rxPhyPacket <= 1'b0;
            rxSelfidPacket <= 1'b0;
            @(negedge clk);
            check(phyPacketAccept, k[0] & asyncReceiveEnabled);
            check(selfidPacketAccept, k[1]);
        end
        // only a reset may drop the lock
        @(posedge clk);
        reset <= 1'b1;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        bud = 8'h00;
        rd(ADDR_LINK_SET);
        check(got, 32'h0);
        check(iso_sync_filter_bit, 1'b0);
        rd(ADDR_FAIRNESS);
        check(got, {24'h0, bud});
        report_and_stop();
    end
endmodule
`default_nettype wire
